/* logic/dfl_top.sv */
// Directional flag logic: direction, timed and polarization flags with AHB-Lite registers
`timescale 1ns/1ps
`include "dfl_params.svh"
module dfl_top
   import dfl_pkg::*;
#(
   parameter int CYC_PER_MS = `DFL_NS_PER_MS / `DFL_CLK_PERIOD_NS,
   parameter int CNT_W      = `DFL_CNT_W
) (
   input  wire logic        CLK_I,
   input  wire logic        RST_I,
   input  wire logic        HSEL_I,
   input  wire logic [31:0] HADDR_I,
   input  wire logic [1:0]  HTRANS_I,
   input  wire logic        HWRITE_I,
   input  wire logic [2:0]  HSIZE_I,
   input  wire logic [31:0] HWDATA_I,
   input  wire logic        HREADY_I,
   output logic      [31:0] HRDATA_O,
   output logic             HREADYOUT_O,
   output logic             HRESP_O,
   input  wire logic [5:0]  OP_VALID_I,
   input  wire logic [5:0]  ANGLE_OK_I,
   input  wire logic [5:0]  POLAR_LOW_I,
   input  wire logic        PHASE_DIR_BLOCK_IN_I,
   input  wire logic        GROUND_DIR_BLOCK_IN_I,
   input  wire logic        NEGSEQ_DIR_BLOCK_IN_I,
   input  wire logic        POSSEQ_DIR_BLOCK_IN_I,
   input  wire logic        ZONE_INVERT_IN_I,
   output logic             PHASE_DIR_BLOCK_IN_O,
   output logic             GROUND_DIR_BLOCK_IN_O,
   output logic             NEGSEQ_DIR_BLOCK_IN_O,
   output logic             POSSEQ_DIR_BLOCK_IN_O,
   output logic             ZONE_INVERT_IN_O,
   output logic             REV_INST_PHASE_A_O,
   output logic             REV_INST_PHASE_B_O,
   output logic             REV_INST_PHASE_C_O,
   output logic             REV_INST_GROUND_O,
   output logic             REV_INST_NEGSEQ_O,
   output logic             REV_INST_POSSEQ_O,
   output logic             REV_TIMED_PHASE_A_O,
   output logic             REV_TIMED_PHASE_B_O,
   output logic             REV_TIMED_PHASE_C_O,
   output logic             REV_TIMED_GROUND_O,
   output logic             REV_TIMED_NEGSEQ_O,
   output logic             REV_TIMED_POSSEQ_O,
   output logic             FWD_INST_PHASE_A_O,
   output logic             FWD_INST_PHASE_B_O,
   output logic             FWD_INST_PHASE_C_O,
   output logic             FWD_INST_GROUND_O,
   output logic             FWD_INST_NEGSEQ_O,
   output logic             FWD_INST_POSSEQ_O,
   output logic             FWD_TIMED_PHASE_A_O,
   output logic             FWD_TIMED_PHASE_B_O,
   output logic             FWD_TIMED_PHASE_C_O,
   output logic             FWD_TIMED_GROUND_O,
   output logic             FWD_TIMED_NEGSEQ_O,
   output logic             POLAR_LOSS_PHASE_A_O,
   output logic             POLAR_LOSS_PHASE_B_O,
   output logic             POLAR_LOSS_PHASE_C_O,
   output logic             POLAR_LOSS_GROUND_O,
   output logic             POLAR_LOSS_NEGSEQ_O,
   output logic             POLAR_LOSS_POSSEQ_O,
   output logic      [5:0]  ELEM_EN_O,
   output logic             IRQ_O
);

   localparam int NE = `DFL_NUM_ELEM;
   localparam int NF = `DFL_NUM_FWD_TIMED;
   localparam int IW = `DFL_IRQ_W;

   // Element index: 0..2 phases A..C, 3 ground, 4 negative, 5 positive sequence
   function automatic dfl_group_t elem_group(input int idx);
      dfl_group_t grp;
      if (idx < 3) begin
         grp = DFL_GRP_PHASE;
      end else if (idx == 3) begin
         grp = DFL_GRP_GROUND;
      end else if (idx == 4) begin
         grp = DFL_GRP_NEGSEQ;
      end else begin
         grp = DFL_GRP_POSSEQ;
      end
      return grp;
   endfunction

   function automatic logic group_blocked(input int idx, input logic [3:0] blk);
      return blk[elem_group(idx)];
   endfunction

   logic [4:0]                    pin_s;
   logic [3:0]                    block_s;
   logic                          invert_s;
   logic [3:0]                    block_mirror;
   logic                          invert_mirror;
   logic [NE-1:0]                 fwd_inst;
   logic [NE-1:0]                 rev_inst;
   logic [NF-1:0]                 fwd_timed;
   logic [NE-1:0]                 rev_timed;
   logic [NE-1:0]                 polar_loss;
   logic [NE-1:0]                 elem_en;
   logic [NE-1:0]                 next_eff;
   logic [NE-1:0]                 next_fwd;
   logic [NE-1:0]                 next_rev;
   logic [NE-1:0]                 next_en;
   logic [`DFL_CTRL_COORD_W-1:0]  coord_ms;
   logic                          pol_blk;
   logic [NE-1:0]                 rev_cfg;
   logic [CNT_W-1:0]              coord_limit;
   logic [IW-1:0]                 irq_stat;
   logic [IW-1:0]                 irq_en;
   logic [IW-1:0]                 next_ev;
   logic [IW-1:0]                 next_clr;
   dfl_bus_state_t                bus_state;
   logic [7:0]                    addr_q;
   logic                          wr_pend;
   logic                          xfer;
   logic [31:0]                   next_rdata;

   dfl_sync #(
      .WIDTH (5)
   ) u_pin_sync (
      .clk_i (CLK_I),
      .rst_i (RST_I),
      .d_i   ({ZONE_INVERT_IN_I, POSSEQ_DIR_BLOCK_IN_I, NEGSEQ_DIR_BLOCK_IN_I,
               GROUND_DIR_BLOCK_IN_I, PHASE_DIR_BLOCK_IN_I}),
      .q_o   (pin_s)
   );

   assign block_s  = pin_s[3:0];
   assign invert_s = pin_s[4];

   // Direction decisions and overcurrent enables per element
   always_comb begin
      for (int i = 0; i < NE; i++) begin
         next_eff[i] = ANGLE_OK_I[i] ^ invert_s;
         next_fwd[i] = OP_VALID_I[i] & ~POLAR_LOW_I[i] & next_eff[i];
         next_rev[i] = OP_VALID_I[i] & ~POLAR_LOW_I[i] & ~next_eff[i];
         if (POLAR_LOW_I[i] && pol_blk) begin
            next_en[i] = 1'b0;
         end else if (group_blocked(i, block_s) || POLAR_LOW_I[i]) begin
            next_en[i] = 1'b1;
         end else if (rev_cfg[i]) begin
            next_en[i] = ~next_eff[i];
         end else begin
            next_en[i] = next_eff[i];
         end
      end
   end

   // Level flags refreshed every clock
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         fwd_inst   <= '0;
         rev_inst   <= '0;
         polar_loss <= '0;
         elem_en    <= '0;
      end else begin
         fwd_inst   <= next_fwd;
         rev_inst   <= next_rev;
         polar_loss <= POLAR_LOW_I;
         elem_en    <= next_en;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         block_mirror  <= '0;
         invert_mirror <= 1'b0;
      end else begin
         block_mirror  <= block_s;
         invert_mirror <= invert_s;
      end
   end

   for (genvar g = 0; g < NE; g++) begin : g_rev_timer
      dfl_coord_timer #(
         .CNT_W (CNT_W)
      ) u_rev_timer (
         .clk_i   (CLK_I),
         .rst_i   (RST_I),
         .cond_i  (next_rev[g]),
         .limit_i (coord_limit),
         .flag_o  (rev_timed[g])
      );
   end

   // Positive sequence has no timed forward flag
   for (genvar g = 0; g < NF; g++) begin : g_fwd_timer
      dfl_coord_timer #(
         .CNT_W (CNT_W)
      ) u_fwd_timer (
         .clk_i   (CLK_I),
         .rst_i   (RST_I),
         .cond_i  (next_fwd[g]),
         .limit_i (coord_limit),
         .flag_o  (fwd_timed[g])
      );
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         coord_limit <= '0;
      end else begin
         coord_limit <= CNT_W'(int'(coord_ms) * CYC_PER_MS);
      end
   end

   // AHB-Lite slave: writes zero-wait, reads take one wait state
   assign xfer = HSEL_I & HTRANS_I[1] & HREADY_I;

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         bus_state   <= DFL_BUS_IDLE;
         HREADYOUT_O <= 1'b1;
         addr_q      <= 8'h00;
         wr_pend     <= 1'b0;
      end else begin
         wr_pend <= 1'b0;
         unique case (bus_state)
            DFL_BUS_IDLE: begin
               if (xfer) begin
                  addr_q <= HADDR_I[7:0];
                  if (HWRITE_I) begin
                     wr_pend <= 1'b1;
                  end else begin
                     bus_state   <= DFL_BUS_READ;
                     HREADYOUT_O <= 1'b0;
                  end
               end
            end
            DFL_BUS_READ: begin
               bus_state   <= DFL_BUS_IDLE;
               HREADYOUT_O <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         HRESP_O <= 1'b0;
      end else begin
         HRESP_O <= 1'b0;
      end
   end

   always_comb begin
      next_rdata = 32'h0000_0000;
      case (addr_q)
         `DFL_ADDR_CTRL: begin
            next_rdata[`DFL_CTRL_COORD_LSB +: `DFL_CTRL_COORD_W] = coord_ms;
            next_rdata[`DFL_CTRL_POLBLK_BIT]                     = pol_blk;
            next_rdata[`DFL_CTRL_REVCFG_LSB +: NE]               = rev_cfg;
         end
         `DFL_ADDR_STATUS: begin
            next_rdata[`DFL_ST_FWD_LSB +: NE]   = fwd_inst;
            next_rdata[`DFL_ST_REV_LSB +: NE]   = rev_inst;
            next_rdata[`DFL_ST_POLAR_LSB +: NE] = polar_loss;
            next_rdata[`DFL_ST_BLOCK_LSB +: 4]  = block_mirror;
            next_rdata[`DFL_ST_INVERT_BIT]      = invert_mirror;
         end
         `DFL_ADDR_TIMED: begin
            next_rdata[`DFL_TM_FWD_LSB +: NF] = fwd_timed;
            next_rdata[`DFL_TM_REV_LSB +: NE] = rev_timed;
         end
         `DFL_ADDR_IRQ_STAT: next_rdata[IW-1:0] = irq_stat;
         `DFL_ADDR_IRQ_EN:   next_rdata[IW-1:0] = irq_en;
         default:            next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         HRDATA_O <= 32'h0000_0000;
      end else if (bus_state == DFL_BUS_READ) begin
         HRDATA_O <= next_rdata;
      end
   end

   // Settings written by software; coordination time saturates at its maximum
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         coord_ms <= `DFL_COORD_RST;
         pol_blk  <= `DFL_POLBLK_RST;
         rev_cfg  <= `DFL_REVCFG_RST;
      end else if (wr_pend && addr_q == `DFL_ADDR_CTRL) begin
         if (HWDATA_I[`DFL_CTRL_COORD_LSB +: `DFL_CTRL_COORD_W] > `DFL_COORD_MAX_MS) begin
            coord_ms <= `DFL_CTRL_COORD_W'(`DFL_COORD_MAX_MS);
         end else begin
            coord_ms <= HWDATA_I[`DFL_CTRL_COORD_LSB +: `DFL_CTRL_COORD_W];
         end
         pol_blk <= HWDATA_I[`DFL_CTRL_POLBLK_BIT];
         rev_cfg <= HWDATA_I[`DFL_CTRL_REVCFG_LSB +: NE];
      end
   end

   // Events: polarization loss rising, inhibit or inversion input changing
   always_comb begin
      next_ev = '0;
      next_ev[`DFL_IRQ_POLAR_LSB +: NE] = POLAR_LOW_I & ~polar_loss;
      next_ev[`DFL_IRQ_BLOCK_LSB +: 4]  = block_s ^ block_mirror;
      next_ev[`DFL_IRQ_INVERT_BIT]      = invert_s ^ invert_mirror;
      next_clr = '0;
      if (wr_pend && addr_q == `DFL_ADDR_IRQ_CLR) begin
         next_clr = HWDATA_I[IW-1:0];
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         irq_stat <= '0;
      end else begin
         irq_stat <= (irq_stat & ~next_clr) | next_ev;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         irq_en <= `DFL_IRQ_EN_RST;
      end else if (wr_pend && addr_q == `DFL_ADDR_IRQ_EN) begin
         irq_en <= HWDATA_I[IW-1:0];
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         IRQ_O <= 1'b0;
      end else begin
         IRQ_O <= |(irq_stat & irq_en);
      end
   end

   // Port mapping of the flag vectors
   assign {POSSEQ_DIR_BLOCK_IN_O, NEGSEQ_DIR_BLOCK_IN_O,
           GROUND_DIR_BLOCK_IN_O, PHASE_DIR_BLOCK_IN_O} = block_mirror;
   assign ZONE_INVERT_IN_O = invert_mirror;
   assign {REV_INST_POSSEQ_O, REV_INST_NEGSEQ_O, REV_INST_GROUND_O,
           REV_INST_PHASE_C_O, REV_INST_PHASE_B_O, REV_INST_PHASE_A_O} = rev_inst;
   assign {REV_TIMED_POSSEQ_O, REV_TIMED_NEGSEQ_O, REV_TIMED_GROUND_O,
           REV_TIMED_PHASE_C_O, REV_TIMED_PHASE_B_O, REV_TIMED_PHASE_A_O} = rev_timed;
   assign {FWD_INST_POSSEQ_O, FWD_INST_NEGSEQ_O, FWD_INST_GROUND_O,
           FWD_INST_PHASE_C_O, FWD_INST_PHASE_B_O, FWD_INST_PHASE_A_O} = fwd_inst;
   assign {FWD_TIMED_NEGSEQ_O, FWD_TIMED_GROUND_O,
           FWD_TIMED_PHASE_C_O, FWD_TIMED_PHASE_B_O, FWD_TIMED_PHASE_A_O} = fwd_timed;
   assign {POLAR_LOSS_POSSEQ_O, POLAR_LOSS_NEGSEQ_O, POLAR_LOSS_GROUND_O,
           POLAR_LOSS_PHASE_C_O, POLAR_LOSS_PHASE_B_O, POLAR_LOSS_PHASE_A_O} = polar_loss;
   assign ELEM_EN_O = elem_en;

   property p_inhibit_phase;
      @(posedge CLK_I) disable iff (RST_I)
      block_s[0] && !POLAR_LOW_I[0] |=> ELEM_EN_O[0];
   endproperty
   a_inhibit_phase: assert property (p_inhibit_phase)
      else $error("Inhibited phase element still directional");

   property p_inhibit_own;
      @(posedge CLK_I) disable iff (RST_I)
      block_s[1] && !block_s[0] && !POLAR_LOW_I[0] && !rev_cfg[0]
         && !(ANGLE_OK_I[0] ^ invert_s) |=> !ELEM_EN_O[0];
   endproperty
   a_inhibit_own: assert property (p_inhibit_own)
      else $error("Ground inhibit acted on a phase element");

   property p_invert;
      @(posedge CLK_I) disable iff (RST_I)
      OP_VALID_I[5] && !POLAR_LOW_I[5] && ANGLE_OK_I[5] && invert_s
         |=> REV_INST_POSSEQ_O && !FWD_INST_POSSEQ_O;
   endproperty
   a_invert: assert property (p_invert)
      else $error("Inversion did not flip the operating zone");

   property p_rev_inst;
      @(posedge CLK_I) disable iff (RST_I)
      OP_VALID_I[3] && !POLAR_LOW_I[3] && !ANGLE_OK_I[3] && !invert_s |=> REV_INST_GROUND_O;
   endproperty
   a_rev_inst: assert property (p_rev_inst)
      else $error("Reverse instantaneous flag missing");

   property p_fwd_inst;
      @(posedge CLK_I) disable iff (RST_I)
      OP_VALID_I[1] && !POLAR_LOW_I[1] && ANGLE_OK_I[1] && !invert_s |=> FWD_INST_PHASE_B_O;
   endproperty
   a_fwd_inst: assert property (p_fwd_inst)
      else $error("Forward instantaneous flag missing");

   property p_polar;
      @(posedge CLK_I) disable iff (RST_I)
      POLAR_LOW_I[4] |=> POLAR_LOSS_NEGSEQ_O && !FWD_INST_NEGSEQ_O && !REV_INST_NEGSEQ_O;
   endproperty
   a_polar: assert property (p_polar)
      else $error("Polarization loss flag wrong");

   property p_mirror;
      @(posedge CLK_I) disable iff (RST_I)
      !$past(RST_I, 1) && !$past(RST_I, 2) && !$past(RST_I, 3)
         |-> ZONE_INVERT_IN_O == $past(ZONE_INVERT_IN_I, 3);
   endproperty
   a_mirror: assert property (p_mirror)
      else $error("Inversion mirror does not follow its input");

   property p_polblk;
      @(posedge CLK_I) disable iff (RST_I)
      POLAR_LOW_I[2] && pol_blk |=> !ELEM_EN_O[2];
   endproperty
   a_polblk: assert property (p_polblk)
      else $error("Element not blocked on lost polarization");

   property p_polnoblk;
      @(posedge CLK_I) disable iff (RST_I)
      POLAR_LOW_I[2] && !pol_blk |=> ELEM_EN_O[2];
   endproperty
   a_polnoblk: assert property (p_polnoblk)
      else $error("Element not made non-directional on lost polarization");

   property p_revcfg;
      @(posedge CLK_I) disable iff (RST_I)
      !block_s[0] && !POLAR_LOW_I[0] && rev_cfg[0] && (ANGLE_OK_I[0] ^ invert_s)
         |=> !ELEM_EN_O[0];
   endproperty
   a_revcfg: assert property (p_revcfg)
      else $error("Reverse element enabled inside the forward zone");

endmodule

/* logic/dfl_params.svh */
// Register map, field positions, reset values and timing of the directional flag logic
`ifndef DFL_PARAMS_SVH
`define DFL_PARAMS_SVH

`define DFL_NUM_ELEM         6
`define DFL_NUM_FWD_TIMED    5

`define DFL_ADDR_CTRL        8'h00
`define DFL_ADDR_STATUS      8'h04
`define DFL_ADDR_TIMED       8'h08
`define DFL_ADDR_IRQ_STAT    8'h0C
`define DFL_ADDR_IRQ_CLR     8'h10
`define DFL_ADDR_IRQ_EN      8'h14

`define DFL_CTRL_COORD_LSB   0
`define DFL_CTRL_COORD_W     5
`define DFL_CTRL_POLBLK_BIT  8
`define DFL_CTRL_REVCFG_LSB  16

`define DFL_ST_FWD_LSB       0
`define DFL_ST_REV_LSB       8
`define DFL_ST_POLAR_LSB     16
`define DFL_ST_BLOCK_LSB     24
`define DFL_ST_INVERT_BIT    28

`define DFL_TM_FWD_LSB       0
`define DFL_TM_REV_LSB       8

`define DFL_IRQ_W            13
`define DFL_IRQ_POLAR_LSB    0
`define DFL_IRQ_BLOCK_LSB    8
`define DFL_IRQ_INVERT_BIT   12

`define DFL_COORD_RST        5'h00
`define DFL_POLBLK_RST       1'b0
`define DFL_REVCFG_RST       6'h00
`define DFL_IRQ_EN_RST       13'h0000

`define DFL_CLK_PERIOD_NS    5
`define DFL_NS_PER_MS        1000000
`define DFL_COORD_MAX_MS     30
`define DFL_CNT_W            23

`endif

/* logic/dfl_pkg.sv */
// Types shared by the directional flag logic
package dfl_pkg;

   typedef enum logic [1:0] {
      DFL_GRP_PHASE,
      DFL_GRP_GROUND,
      DFL_GRP_NEGSEQ,
      DFL_GRP_POSSEQ
   } dfl_group_t;

   typedef enum logic {
      DFL_BUS_IDLE,
      DFL_BUS_READ
   } dfl_bus_state_t;

endpackage

/* logic/dfl_sync.sv */
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module dfl_sync #(
   parameter int WIDTH = 5
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);

   logic [WIDTH-1:0] stage1;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stage1 <= '0;
         q_o    <= '0;
      end else begin
         stage1 <= d_i;
         q_o    <= stage1;
      end
   end

endmodule

/* logic/dfl_coord_timer.sv */
// Coordination timer: raises its flag once its condition has lasted one cycle more than the set cycles
`timescale 1ns/1ps
module dfl_coord_timer #(
   parameter int CNT_W = 23
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             cond_i,
   input  wire logic [CNT_W-1:0] limit_i,
   output logic                  flag_o
);

   logic [CNT_W-1:0] cnt;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt    <= '0;
         flag_o <= 1'b0;
      end else if (!cond_i) begin
         cnt    <= '0;
         flag_o <= 1'b0;
      end else if (cnt >= limit_i) begin
         flag_o <= 1'b1;
      end else begin
         cnt    <= cnt + 1'b1;
      end
   end

   property p_timer_drop;
      @(posedge clk_i) disable iff (rst_i)
      !cond_i |=> !flag_o && (cnt == '0);
   endproperty
   a_timer_drop: assert property (p_timer_drop)
      else $error("Timed flag did not clear when its condition dropped");

   property p_timer_early;
      @(posedge clk_i) disable iff (rst_i)
      $rose(flag_o) |-> $past(cond_i) && ($past(cnt) >= $past(limit_i));
   endproperty
   a_timer_early: assert property (p_timer_early)
      else $error("Timed flag rose before the coordination time elapsed");

   property p_timer_fire;
      @(posedge clk_i) disable iff (rst_i)
      cond_i && (cnt >= limit_i) |=> flag_o;
   endproperty
   a_timer_fire: assert property (p_timer_fire)
      else $error("Timed flag missing after the coordination time");

endmodule

/* tb/dfl_oc_model.sv */
// Partner model: overcurrent elements supervised by the directional enables
`timescale 1ns/1ps
module dfl_oc_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [5:0] elem_en_i,
   input  wire logic [5:0] pickup_i,
   output logic      [5:0] trip_o
);
   // A picked-up element trips only while its enable allows it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trip_o <= 6'h00;
      end else begin
         trip_o <= pickup_i & elem_en_i;
      end
   end
endmodule

/* tb/tb_directional_flag_logic.sv */
// Self-checking bench for the directional flag logic
`timescale 1ns/1ps
module tb_directional_flag_logic;
   logic CLK_I = 1'b0, RST_I = 1'b1, HSEL_I = 1'b0, HWRITE_I = 1'b0;
   logic [31:0] HADDR_I = 32'h0, HWDATA_I = 32'h0, HRDATA_O, q;
   logic [1:0] HTRANS_I = 2'h0;
   logic [2:0] HSIZE_I = 3'h2;
   logic HREADYOUT_O, HRESP_O, IRQ_O, ZONE_INVERT_IN_I = 1'b0;
   wire HREADY_I = HREADYOUT_O;
   logic [5:0] OP_VALID_I = 6'h00, ANGLE_OK_I = 6'h00, POLAR_LOW_I = 6'h00;
   logic [5:0] ELEM_EN_O, pick = 6'h00, trip;
   logic PHASE_DIR_BLOCK_IN_I = 1'b0, GROUND_DIR_BLOCK_IN_I = 1'b0;
   logic NEGSEQ_DIR_BLOCK_IN_I = 1'b0, POSSEQ_DIR_BLOCK_IN_I = 1'b0;
   logic PHASE_DIR_BLOCK_IN_O, GROUND_DIR_BLOCK_IN_O, NEGSEQ_DIR_BLOCK_IN_O;
   logic POSSEQ_DIR_BLOCK_IN_O, ZONE_INVERT_IN_O;
   logic REV_INST_PHASE_A_O, REV_INST_PHASE_B_O, REV_INST_PHASE_C_O, REV_INST_GROUND_O;
   logic REV_INST_NEGSEQ_O, REV_INST_POSSEQ_O, REV_TIMED_PHASE_A_O, REV_TIMED_PHASE_B_O;
   logic REV_TIMED_PHASE_C_O, REV_TIMED_GROUND_O, REV_TIMED_NEGSEQ_O, REV_TIMED_POSSEQ_O;
   logic FWD_INST_PHASE_A_O, FWD_INST_PHASE_B_O, FWD_INST_PHASE_C_O, FWD_INST_GROUND_O;
   logic FWD_INST_NEGSEQ_O, FWD_INST_POSSEQ_O, FWD_TIMED_PHASE_A_O, FWD_TIMED_PHASE_B_O;
   logic FWD_TIMED_PHASE_C_O, FWD_TIMED_GROUND_O, FWD_TIMED_NEGSEQ_O;
   logic POLAR_LOSS_PHASE_A_O, POLAR_LOSS_PHASE_B_O, POLAR_LOSS_PHASE_C_O;
   logic POLAR_LOSS_GROUND_O, POLAR_LOSS_NEGSEQ_O, POLAR_LOSS_POSSEQ_O;
   int fail_count = 0;
   int n_checks = 0;
   wire [5:0] fi = {FWD_INST_POSSEQ_O, FWD_INST_NEGSEQ_O, FWD_INST_GROUND_O,
                    FWD_INST_PHASE_C_O, FWD_INST_PHASE_B_O, FWD_INST_PHASE_A_O};
   wire [5:0] ri = {REV_INST_POSSEQ_O, REV_INST_NEGSEQ_O, REV_INST_GROUND_O,
                    REV_INST_PHASE_C_O, REV_INST_PHASE_B_O, REV_INST_PHASE_A_O};
   wire [5:0] pl = {POLAR_LOSS_POSSEQ_O, POLAR_LOSS_NEGSEQ_O, POLAR_LOSS_GROUND_O,
                    POLAR_LOSS_PHASE_C_O, POLAR_LOSS_PHASE_B_O, POLAR_LOSS_PHASE_A_O};
   wire [4:0] ft = {FWD_TIMED_NEGSEQ_O, FWD_TIMED_GROUND_O, FWD_TIMED_PHASE_C_O,
                    FWD_TIMED_PHASE_B_O, FWD_TIMED_PHASE_A_O};
   wire [5:0] rt = {REV_TIMED_POSSEQ_O, REV_TIMED_NEGSEQ_O, REV_TIMED_GROUND_O,
                    REV_TIMED_PHASE_C_O, REV_TIMED_PHASE_B_O, REV_TIMED_PHASE_A_O};
   wire [4:0] mir = {ZONE_INVERT_IN_O, POSSEQ_DIR_BLOCK_IN_O, NEGSEQ_DIR_BLOCK_IN_O,
                     GROUND_DIR_BLOCK_IN_O, PHASE_DIR_BLOCK_IN_O};

   dfl_top #(.CYC_PER_MS(4)) uut (.*);
   dfl_oc_model partner (.clk_i(CLK_I), .rst_i(RST_I), .elem_en_i(ELEM_EN_O),
                         .pickup_i(pick), .trip_o(trip));

   always #2.5 CLK_I = ~CLK_I;

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge CLK_I);
      @(negedge CLK_I);
   endtask

   // One single-word transfer; holds each phase until hready is seen high
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      logic r;
      @(posedge CLK_I);
      HSEL_I <= 1'b1;
      HTRANS_I <= 2'h2;
      HADDR_I <= {24'h000000, a};
      HWRITE_I <= w;
      do begin @(negedge CLK_I); r = HREADYOUT_O; @(posedge CLK_I); end while (r !== 1'b1);
      HTRANS_I <= 2'h0;
      HWDATA_I <= d;
      do begin @(negedge CLK_I); r = HREADYOUT_O; q = HRDATA_O; @(posedge CLK_I); end
      while (r !== 1'b1);
   endtask

   task set_in(input logic [5:0] op, input logic [5:0] ang, input logic [5:0] plw);
      @(posedge CLK_I);
      OP_VALID_I <= op;
      ANGLE_OK_I <= ang;
      POLAR_LOW_I <= plw;
   endtask

   task t_regs;
      bus(1'b0, 8'h00, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, 8'h00, 32'h0000001F);
      bus(1'b0, 8'h00, 32'h0);
      chk(q, 32'h0000001E);
      bus(1'b1, 8'h00, 32'h00000001);
      bus(1'b0, 8'h00, 32'h0);
      chk(q, 32'h00000001);
      bus(1'b0, 8'h40, 32'h0);
      chk(q, 32'h0);
      chk(HRESP_O, 1'b0);
   endtask

   task t_fwd;
      set_in(6'h3F, 6'h3F, 6'h00);
      cyc(1);
      chk(fi, 6'h3F);
      chk(ELEM_EN_O, 6'h3F);
      cyc(3);
      chk(ft, 5'h00);
      cyc(1);
      chk({ft, ri}, {5'h1F, 6'h00});
      set_in(6'h00, 6'h3F, 6'h00);
      cyc(1);
      chk({fi, ft}, 11'h000);
   endtask

   task t_rev;
      @(posedge CLK_I) ZONE_INVERT_IN_I <= 1'b1;
      cyc(3);
      set_in(6'h3F, 6'h3F, 6'h00);
      cyc(1);
      chk({ri, fi}, {6'h3F, 6'h00});
      chk(mir, 5'h10);
      cyc(3);
      chk(rt, 6'h00);
      cyc(1);
      chk(rt, 6'h3F);
      chk(ELEM_EN_O, 6'h00);
      bus(1'b0, 8'h08, 32'h0);
      chk(q, 32'h00003F00);
      bus(1'b0, 8'h04, 32'h0);
      chk(q, 32'h10003F00);
   endtask

   task t_inh;
      logic [5:0] grp [4];
      grp = '{6'h07, 6'h08, 6'h10, 6'h20};
      for (int i = 0; i < 4; i++) begin
         @(posedge CLK_I);
         {POSSEQ_DIR_BLOCK_IN_I, NEGSEQ_DIR_BLOCK_IN_I, GROUND_DIR_BLOCK_IN_I,
          PHASE_DIR_BLOCK_IN_I} <= 4'h1 << i;
         cyc(3);
         chk(ELEM_EN_O, grp[i]);
         chk(mir, 5'h10 | (5'h01 << i));
         chk(ri, 6'h3F);
      end
      @(posedge CLK_I);
      {POSSEQ_DIR_BLOCK_IN_I, NEGSEQ_DIR_BLOCK_IN_I, GROUND_DIR_BLOCK_IN_I,
       PHASE_DIR_BLOCK_IN_I, ZONE_INVERT_IN_I} <= 5'h00;
      bus(1'b1, 8'h00, 32'h003F0001);
      set_in(6'h3F, 6'h2A, 6'h00);
      cyc(3);
      chk({ELEM_EN_O, fi, ri}, {6'h15, 6'h2A, 6'h15});
   endtask

   task t_pol;
      bus(1'b1, 8'h00, 32'h00000001);
      bus(1'b1, 8'h10, 32'h00001FFF);
      bus(1'b1, 8'h14, 32'h0000003F);
      set_in(6'h3F, 6'h00, 6'h15);
      pick <= 6'h3F;
      cyc(2);
      chk({pl, ELEM_EN_O, fi}, {6'h15, 6'h15, 6'h00});
      chk({IRQ_O, trip}, {1'b1, 6'h15});
      bus(1'b0, 8'h0C, 32'h0);
      chk(q, 32'h00000015);
      bus(1'b1, 8'h14, 32'h0);
      cyc(1);
      chk(IRQ_O, 1'b0);
      bus(1'b1, 8'h00, 32'h00000101);
      cyc(1);
      chk(ELEM_EN_O, 6'h00);
      set_in(6'h00, 6'h00, 6'h00);
      bus(1'b1, 8'h10, 32'h00000015);
      bus(1'b0, 8'h0C, 32'h0);
      chk(q, 32'h0);
   endtask

   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge CLK_I);
      RST_I <= 1'b0;
      cyc(3);
      chk({HREADYOUT_O, IRQ_O, ELEM_EN_O, fi, ri, pl}, {1'b1, 25'h0});
      t_regs();
      t_fwd();
      t_rev();
      t_inh();
      t_pol();
      tally_and_finish();
   end

   initial begin
      repeat (20000) @(posedge CLK_I);
      fail_count++;
      tally_and_finish();
   end
endmodule
